// *** hdl/ebm_config.sv ***
// external bus mode configuration, byte select and access sequencer
`default_nettype none
module ebm_config
  import ebm_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        busStrapLow,
  input  wire logic        busStrapHigh,
  input  wire logic        cfgWrite,
  input  wire logic [15:0] cfgWdata,
  output logic      [15:0] cfgRdata,
  input  wire ebm_req_type req,
  input  wire logic        reqValid,
  output logic             reqReady,
  output logic             reqDone,
  output logic      [15:0] rdData,
  output logic             trapPulse,
  output logic      [17:0] instrPointer,
  output logic             romEnable,
  output logic      [5:0]  timingParams,
  output logic      [15:0] port0Out,
  output logic      [15:0] port0Oe,
  input  wire logic [15:0] port0In,
  output logic      [15:0] port1Out,
  output logic             port1Oe,
  output logic      [1:0]  port4Seg,
  output logic             port4SegOe,
  output logic             addrLatchStrobe,
  output logic             readStrobeN,
  output logic             writeStrobeN,
  output logic             byteHighEnableN,
  output logic             byteHighOe
);

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_ADDR   = 4'h2,
    ST_STROBE = 4'h4,
    ST_NEXT   = 4'h8
  } ebm_state_type;

  // configuration state
  ebm_cfg_type cfg_q, cfg_d;
  logic        captured_q, captured_d;
  logic        singleAtReset_q, singleAtReset_d;

  // strap capture on the first edge after release, never under reset
  always_comb
  begin
    cfg_d = cfg_q;
    captured_d = 1'b1;
    singleAtReset_d = singleAtReset_q;
    if (!captured_q)
    begin
      cfg_d.busType = {busStrapHigh, busStrapLow};
      cfg_d.romEnable = ({busStrapHigh, busStrapLow} == BUS_TYPE_SINGLE);
      singleAtReset_d = ({busStrapHigh, busStrapLow} == BUS_TYPE_SINGLE);
    end
    else if (cfgWrite)
    begin
      // rom enable untouched by software
      if (singleAtReset_q)
        cfg_d.busType = cfgWdata[BUS_TYPE_MSB_POS:BUS_TYPE_LSB_POS];
      cfg_d.segDisable = cfgWdata[SEG_DISABLE_POS];
      cfg_d.byteDisable = cfgWdata[BYTE_DISABLE_POS];
      cfg_d.timing = cfgWdata[TIMING_LSB_POS +: 6];
    end
  end

  // straps ignored once captured_q is set
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cfg_q <= '{busType: BUS_TYPE_SINGLE, romEnable: 1'b0, segDisable: 1'b0,
                 byteDisable: 1'b0, timing: TIMING_RESET};
      captured_q <= 1'b0;
      singleAtReset_q <= 1'b0;
    end
    else
    begin
      cfg_q <= cfg_d;
      captured_q <= captured_d;
      singleAtReset_q <= singleAtReset_d;
    end
  end

  // readback image of the configuration register
  always_comb
  begin
    cfgRdata = 16'h0000;
    cfgRdata[BUS_TYPE_MSB_POS:BUS_TYPE_LSB_POS] = cfg_q.busType;
    cfgRdata[ROM_ENABLE_POS] = cfg_q.romEnable;
    cfgRdata[SEG_DISABLE_POS] = cfg_q.segDisable;
    cfgRdata[BYTE_DISABLE_POS] = cfg_q.byteDisable;
    cfgRdata[TIMING_LSB_POS +: 6] = cfg_q.timing;
  end

  assign romEnable = cfg_q.romEnable;
  assign timingParams = cfg_q.timing;
  assign instrPointer = START_ADDR;

  // mode decode
  logic isSingle, isMux8, is16, isMux;
  assign isSingle = (cfg_q.busType == BUS_TYPE_SINGLE);
  assign isMux8 = (cfg_q.busType == BUS_TYPE_MUX8);
  assign is16 = (cfg_q.busType == BUS_TYPE_MUX16) || (cfg_q.busType == BUS_TYPE_DMX16);
  assign isMux = isMux8 || (cfg_q.busType == BUS_TYPE_MUX16);
  logic bheActive;
  assign bheActive = is16 && !cfg_q.byteDisable;

  // internal window test: sfr space always, rom low space when enabled
  logic isInternal;
  assign isInternal = (req.addr >= SFR_BASE && req.addr <= SFR_LAST) ||
                      (cfg_q.romEnable && req.addr <= ROM_LAST);

  // access sequencer
  ebm_state_type state_q, state_d;
  ebm_req_type   cur_q, cur_d;
  logic [2:0]    cnt_q, cnt_d;
  logic          second_q, second_d;
  logic [15:0]   rd_q, rd_d;
  logic          done_q, done_d;
  logic          trap_q, trap_d;
  logic [17:0]   curAddr;

  // second mux8 byte goes to the next address
  assign curAddr = second_q ? (cur_q.addr | 18'h00001) : cur_q.addr;
  assign reqReady = (state_q == ST_IDLE);

  always_comb
  begin
    state_d = state_q;
    cur_d = cur_q;
    cnt_d = cnt_q;
    second_d = second_q;
    rd_d = rd_q;
    done_d = 1'b0;
    trap_d = 1'b0;
    case (state_q)
      ST_IDLE:
        if (reqValid && !isInternal)
        begin
          if (isSingle)
            trap_d = 1'b1;
          else
          begin
            cur_d = req;
            cur_d.isWord = req.isWord && !req.addr[0];
            second_d = 1'b0;
            cnt_d = 3'(ADDR_CYCLES);
            state_d = ST_ADDR;
          end
        end
      ST_ADDR:
        if (cnt_q == 3'h1)
        begin
          cnt_d = 3'(STROBE_CYCLES);
          state_d = ST_STROBE;
        end
        else
          cnt_d = cnt_q - 3'h1;
      ST_STROBE:
        if (cnt_q == 3'h1)
        begin
          if (!cur_q.write)
          begin
            if (isMux8 && second_q)
              rd_d[15:8] = port0In[7:0];
            else if (isMux8)
              rd_d = {8'h00, port0In[7:0]};
            else
              rd_d = port0In;
          end
          if (isMux8 && cur_q.isWord && !second_q)
          begin
            second_d = 1'b1;
            state_d = ST_NEXT;
          end
          else
          begin
            done_d = 1'b1;
            state_d = ST_IDLE;
          end
        end
        else
          cnt_d = cnt_q - 3'h1;
      ST_NEXT:
      begin
        cnt_d = 3'(ADDR_CYCLES);
        state_d = ST_ADDR;
      end
      default:
        state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= ST_IDLE;
      cur_q <= '0;
      cnt_q <= 3'h0;
      second_q <= 1'b0;
      rd_q <= 16'h0000;
      done_q <= 1'b0;
      trap_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cur_q <= cur_d;
      cnt_q <= cnt_d;
      second_q <= second_d;
      rd_q <= rd_d;
      done_q <= done_d;
      trap_q <= trap_d;
    end
  end

  assign reqDone = done_q;
  assign rdData = rd_q;
  assign trapPulse = trap_q;

  // pin drive; single chip leaves every pin to general purpose control
  logic        busy;
  logic [15:0] wordOut;
  assign busy = (state_q == ST_ADDR) || (state_q == ST_STROBE);
  always_comb
  begin
    wordOut = cur_q.wdata;
    if (isMux8)
      wordOut = {8'h00, second_q ? cur_q.wdata[15:8] : cur_q.wdata[7:0]};
    else if (!cur_q.isWord)
      wordOut = curAddr[0] ? {2{cur_q.wdata[15:8]}} : {2{cur_q.wdata[7:0]}};
  end

  always_comb
  begin
    port0Out = 16'h0000;
    port0Oe = 16'h0000;
    port1Out = 16'h0000;
    port1Oe = 1'b0;
    addrLatchStrobe = 1'b0;
    readStrobeN = 1'b1;
    writeStrobeN = 1'b1;
    if (busy && !isSingle)
    begin
      if (isMux)
      begin
        port0Out = curAddr[15:0];
        port0Oe = 16'hFFFF;
        // strobe in the first address cycle; address held one more cycle
        addrLatchStrobe = (state_q == ST_ADDR) && (cnt_q == 3'(ADDR_CYCLES));
        if (state_q == ST_STROBE)
        begin
          port0Out = isMux8 ? {curAddr[15:8], wordOut[7:0]} : wordOut;
          port0Oe = cur_q.write ? 16'hFFFF : (isMux8 ? 16'hFF00 : 16'h0000);
        end
      end
      else
      begin
        port1Out = curAddr[15:0];
        port1Oe = 1'b1;
        port0Out = wordOut;
        port0Oe = (cur_q.write && state_q == ST_STROBE) ? 16'hFFFF : 16'h0000;
      end
      readStrobeN = !(state_q == ST_STROBE && !cur_q.write);
      writeStrobeN = !(state_q == ST_STROBE && cur_q.write);
    end
  end

  // segment bits and byte-high select
  assign port4SegOe = !isSingle && !cfg_q.segDisable;
  assign port4Seg = port4SegOe ? curAddr[17:16] : 2'h0;
  assign byteHighOe = bheActive;
  // low-only byte access deasserts high select; never with A0 high
  assign byteHighEnableN = bheActive && busy && !cur_q.isWord && !curAddr[0];

endmodule // ebm_config
`default_nettype wire

// *** pkg/ebm_pkg.sv ***
// package for the external bus mode configuration block
`default_nettype none
package ebm_pkg;
  // bus-type field encodings
  localparam logic [1:0] BUS_TYPE_SINGLE = 2'h0;
  localparam logic [1:0] BUS_TYPE_MUX8   = 2'h1;
  localparam logic [1:0] BUS_TYPE_MUX16  = 2'h2;
  localparam logic [1:0] BUS_TYPE_DMX16  = 2'h3;
  // configuration register field positions
  localparam int BUS_TYPE_LSB_POS  = 6;
  localparam int BUS_TYPE_MSB_POS  = 7;
  localparam int ROM_ENABLE_POS    = 12;
  localparam int SEG_DISABLE_POS   = 11;
  localparam int BYTE_DISABLE_POS  = 9;
  // timing field: slowest setting after reset
  localparam int TIMING_LSB_POS    = 0;
  localparam logic [5:0] TIMING_SLOWEST = 6'h3F;
  localparam logic [5:0] TIMING_RESET   = TIMING_SLOWEST;
  localparam logic [17:0] START_ADDR    = 18'h00000;
  // internal-only windows
  localparam logic [17:0] SFR_BASE      = 18'h0FA00;
  localparam logic [17:0] SFR_LAST      = 18'h0FFFF;
  localparam logic [17:0] ROM_LAST      = 18'h01FFF;
  // bus phase timing in cycles
  localparam int ADDR_CYCLES   = 2;
  localparam int STROBE_CYCLES = 2;

  typedef struct packed {
    logic [1:0] busType;
    logic       romEnable;
    logic       segDisable;
    logic       byteDisable;
    logic [5:0] timing;
  } ebm_cfg_type;

  typedef struct packed {
    logic [17:0] addr;
    logic [15:0] wdata;
    logic        write;
    logic        isWord;
  } ebm_req_type;
endpackage : ebm_pkg
`default_nettype wire

// *** tb/ebm_config_properties.sv ***
// concurrent checks on the bus mode configuration ports
`default_nettype none
module ebm_config_properties
  import ebm_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic [15:0] cfgRdata,
  input wire logic        trapPulse,
  input wire logic [17:0] instrPointer,
  input wire logic        romEnable,
  input wire logic [5:0]  timingParams,
  input wire logic [15:0] port0Out,
  input wire logic [15:0] port1Out,
  input wire logic        port4SegOe,
  input wire logic        addrLatchStrobe,
  input wire logic        readStrobeN,
  input wire logic        writeStrobeN,
  input wire logic        byteHighEnableN,
  input wire logic        byteHighOe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic idle;
  // no strobe low means no bus cycle
  assign idle = readStrobeN && writeStrobeN;
  a_rom_frozen: assert property ($past(rst_b, 2) |-> $stable(romEnable))
    else $error("rom enable moved after reset");
  a_timing_slow: assert property (!$past(rst_b) |-> timingParams == TIMING_RESET)
    else $error("timing not slowest after reset");
  a_ip_clear: assert property (instrPointer == START_ADDR)
    else $error("instruction pointer not cleared");
  a_trap_quiet: assert property (trapPulse |-> cfgRdata[7:6] == BUS_TYPE_SINGLE && idle)
    else $error("trap outside single chip or with bus cycle");
  a_single_idle: assert property (cfgRdata[7:6] == BUS_TYPE_SINGLE
    |-> idle && !addrLatchStrobe && !port4SegOe) else $error("bus active in single chip");
  a_seg_drive: assert property (port4SegOe |-> cfgRdata[7:6] != 2'h0 && !cfgRdata[11])
    else $error("segment pins driven when not allowed");
  a_bhe_gate: assert property (byteHighOe |-> cfgRdata[7] && !cfgRdata[9])
    else $error("byte high enable driven when disabled");
  a_bhe_code: assert property (!idle && byteHighOe && cfgRdata[7:6] == BUS_TYPE_DMX16
    |-> !(byteHighEnableN && port1Out[0])) else $error("byte high and A0 both high");
  a_ale_order: assert property ($rose(addrLatchStrobe)
    |-> idle ##1 !addrLatchStrobe ##[1:3] !idle) else $error("latch strobe order wrong");
  // a single selected byte lane must still see the byte on both halves
  a_byte_both: assert property (cfgRdata[7:6] == BUS_TYPE_DMX16 && byteHighOe
    && !writeStrobeN && (byteHighEnableN || port1Out[0])
    |-> port0Out[15:8] == port0Out[7:0]) else $error("byte write not on both halves");
endmodule // ebm_config_properties
bind ebm_config ebm_config_properties ebm_config_properties_i (.ref_clk, .rst_b, .cfgRdata,
  .trapPulse, .instrPointer, .romEnable, .timingParams, .port0Out, .port1Out, .port4SegOe,
  .addrLatchStrobe, .readStrobeN, .writeStrobeN, .byteHighEnableN, .byteHighOe);
`default_nettype wire

// *** tb/ebm_config_tb_top.sv ***
// self-checking bench for the bus mode configuration block
`default_nettype none
module ebm_config_tb_top
  import ebm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0, rst_b = 1'b0, cfgWrite = 1'b0, reqValid = 1'b0;
  logic        strapLow = 1'b0, strapHigh = 1'b0, trapSeen;
  logic [1:0]  mode = 2'h0;
  logic [15:0] cfgWdata = 16'h0000, rd;
  ebm_req_type req = '0;
  logic [15:0] cfgRdata, rdData, port0Out, port0In, port1Out, port0Oe, oeSeen;
  logic [1:0]  port4Seg, segSeen;
  logic        port1Oe, p1OeSeen, port4SegOe, byteHighOe;
  logic [17:0] instrPointer;
  logic [5:0]  timingParams;
  logic        reqReady, reqDone, trapPulse, romEnable, addrLatchStrobe;
  logic        readStrobeN, writeStrobeN, byteHighEnableN;
  int          nFail = 0, numChecks = 0;
  always #4 ref_clk = ~ref_clk;
  ebm_config ebm_config_i (.ref_clk, .rst_b, .busStrapLow(strapLow), .busStrapHigh(strapHigh),
    .cfgWrite, .cfgWdata, .cfgRdata, .req, .reqValid, .reqReady, .reqDone, .rdData,
    .trapPulse, .instrPointer, .romEnable, .timingParams, .port0Out, .port0Oe, .port0In,
    .port1Out, .port1Oe, .port4Seg, .port4SegOe, .addrLatchStrobe, .readStrobeN,
    .writeStrobeN, .byteHighEnableN, .byteHighOe);
  ebm_mem_model ebm_mem_model_i (.ref_clk, .mode, .port0Out, .port1Out, .addrLatchStrobe,
    .readStrobeN, .writeStrobeN, .byteHighEnableN, .port0In);
  // pin state seen while the read strobe is low, compared after the access
  always @(posedge ref_clk)
    if (!readStrobeN)
      {segSeen, oeSeen, p1OeSeen} <= {port4Seg, port0Oe, port1Oe};
  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    numChecks++;
    if (seen !== exp)
    begin
      nFail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", numChecks, nFail);
    if (nFail == 0 && numChecks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // reset with straps, then flip straps to show they no longer count
  task automatic boot(input logic [1:0] m);
    @(posedge ref_clk);
    rst_b <= 1'b0;
    {strapHigh, strapLow} <= m;
    mode <= m;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge ref_clk);
    {strapHigh, strapLow} <= ~m;
    // two edges so a design that kept sampling the straps would show it
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic cfg(input logic [15:0] d);
    @(posedge ref_clk);
    cfgWrite <= 1'b1;
    cfgWdata <= d;
    @(posedge ref_clk);
    cfgWrite <= 1'b0;
    @(posedge ref_clk);
  endtask
  // request held until the edge that takes it, bounded waits
  task automatic acc(input logic [17:0] a, input logic [15:0] d, input logic w, input logic wd);
    int n;
    n = 0;
    @(posedge ref_clk);
    req <= '{addr: a, wdata: d, write: w, isWord: wd};
    reqValid <= 1'b1;
    do @(posedge ref_clk); while (reqReady !== 1'b1 && ++n < 20);
    reqValid <= 1'b0;
    do @(posedge ref_clk); while (reqDone !== 1'b1 && trapPulse !== 1'b1 && ++n < 40);
    rd = rdData;
    trapSeen = trapPulse;
    if (n >= 40) nFail++;
  endtask
  task automatic rw(input logic [17:0] a, input logic [15:0] d);
    acc(a, d, 1'b1, 1'b1);
    acc(a, 16'h0000, 1'b0, 1'b1);
    chk(rd, d);
    chk(trapSeen, 1'b0);
  endtask
  // about 260 cycles expected; 20 us leaves wide margin
  initial
  begin
    #20us;
    nFail++;
    close_out();
  end
  initial
  begin
    boot(BUS_TYPE_SINGLE);
    chk(cfgRdata[7:6], BUS_TYPE_SINGLE);
    chk(romEnable, 1'b1);
    chk(timingParams, TIMING_RESET);
    chk(instrPointer, START_ADDR);
    chk(port4SegOe, 1'b0);
    cfg(16'h0005);
    chk(cfgRdata[12], 1'b1);
    acc(18'h02000, 16'h1234, 1'b1, 1'b1);
    chk(trapSeen, 1'b1);
    cfg(16'h0045);
    mode <= BUS_TYPE_MUX8;
    chk(cfgRdata[7:6], BUS_TYPE_MUX8);
    chk(romEnable, 1'b1);
    rw(18'h02000, 16'hBEEF);
    for (int m = 1; m < 4; m++)
    begin
      boot(m[1:0]);
      chk(cfgRdata[7:6], m[1:0]);
      chk(romEnable, 1'b0);
      chk(timingParams, TIMING_RESET);
      chk(port4SegOe, 1'b1);
      chk(byteHighOe, m[1]);
      cfg(16'h1005);
      chk(cfgRdata[7:6], m[1:0]);
      chk(cfgRdata[12], 1'b0);
      rw(18'h02010, 16'hA5C3);
      acc(18'h02013, 16'h7E7E, 1'b1, 1'b0);
      acc(18'h02012, 16'h1919, 1'b1, 1'b0);
      acc(18'h32012, 16'h0000, 1'b0, 1'b1);
      chk(rd, 16'h7E19);
      chk(segSeen, 2'h3);
      chk(oeSeen, (m == 1) ? 16'hFF00 : 16'h0000);
      chk(p1OeSeen, m == 3);
      cfg(16'h0A05 | (16'(m) << 6));
      chk(port4SegOe, 1'b0);
      chk(byteHighOe, 1'b0);
      rw(18'h02020, 16'h5A0F);
    end
    close_out();
  end
endmodule // ebm_config_tb_top
`default_nettype wire

// *** tb/ebm_mem_model.sv ***
// byte-pair external memory with its address latch
`default_nettype none
module ebm_mem_model
  import ebm_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic [1:0]  mode,
  input  wire logic [15:0] port0Out,
  input  wire logic [15:0] port1Out,
  input  wire logic        addrLatchStrobe,
  input  wire logic        readStrobeN,
  input  wire logic        writeStrobeN,
  input  wire logic        byteHighEnableN,
  output logic      [15:0] port0In
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [7:0] latchQ, a, ev;
  logic       wide;
  assign wide = mode != BUS_TYPE_MUX8;
  assign a = (mode == BUS_TYPE_DMX16) ? port1Out[7:0] : latchQ;
  assign ev = {a[7:1], 1'b0};
  initial port0In = 16'h0000;
  // released bus toggles so a stale value never reads as good
  always @(posedge ref_clk)
  begin
    if (addrLatchStrobe) latchQ <= port0Out[7:0];
    if (!readStrobeN) port0In <= wide ? {mem[ev | 8'h01], mem[ev]} : {8'h00, mem[a]};
    else port0In <= ~port0In;
    if (!writeStrobeN && !wide) mem[a] <= port0Out[7:0];
    if (!writeStrobeN && wide && !a[0]) mem[ev] <= port0Out[7:0];
    if (!writeStrobeN && wide && !byteHighEnableN) mem[ev | 8'h01] <= port0Out[15:8];
  end
endmodule // ebm_mem_model
`default_nettype wire
